//--- inc/gtm_pkg.sv
// Constants, register map and field layout of the 16-bit timer.
// Assumes a 32-bit AHB-Lite bus, one register per aligned word.
package gtm_pkg;
   // Register indices; byte address is four times the index
   localparam logic [11:0] IDX_COUNT   = 12'h100;
   localparam logic [11:0] IDX_PERIOD  = 12'h102;
   localparam logic [11:0] IDX_CONTROL = 12'h104;
   localparam logic [11:0] IDX_STATUS  = 12'h106;
   localparam logic [11:0] IDX_MASK    = 12'h108;
   localparam logic [11:0] IDX_OSC     = 12'h10a;
   localparam int          ADDR_LSB    = 2;
   localparam int          ADDR_W      = 14;

   localparam logic [15:0] PERIOD_RST  = 16'hffff;
   localparam logic [15:0] CONTROL_RST = 16'h0000;
   localparam logic [15:0] COUNT_RST   = 16'h0000;

   // Status and mask layout
   localparam int ST_IRQ  = 0;
   localparam int ST_WAKE = 1;
   localparam int ST_W    = 2;
   // Oscillator control field
   localparam int OSC_LPE = 1;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'b0;

   localparam int PS_W = 8;
   // Terminal counts for 1:1, 1:8, 1:64, 1:256
   localparam logic [PS_W-1:0] PS_TERM [4] = '{8'h00, 8'h07, 8'h3f, 8'hff};

   typedef struct packed {
      logic       timer_on;
      logic       rsv14;
      logic       stop_in_idle;
      logic [5:0] rsv12_7;
      logic       gate_enable;
      logic [1:0] prescale_select;
      logic       rsv3;
      logic       ext_clock_sync;
      logic       clock_source_select;
      logic       rsv0;
   } gtm_ctrl_t;

   // Writable bits of the control word; reserved bits read zero
   localparam logic [15:0] CONTROL_WMASK = 16'ha076;

   typedef struct packed {
      logic              write;
      logic              valid;
      logic [ADDR_W-1:0] index;
   } gtm_aphase_t;
endpackage : gtm_pkg

//--- design/gtm_edge_det.sv
// Edge detector for a pin, with optional two-stage synchroniser.
// Assumes the pin is sampled on hclk.
module gtm_edge_det (
   // Clock and reset
   input  wire logic hclk,
   input  wire logic hresetn,
   // Pin and mode
   input  wire logic pin,
   input  wire logic sync_en,
   // Results
   output logic      level,
   output logic      rise,
   output logic      fall
);
   logic sync1;
   logic sync2;
   logic sync_prev;
   logic raw_prev;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1     <= 1'b0;
         sync2     <= 1'b0;
         sync_prev <= 1'b0;
         raw_prev  <= 1'b0;
      end else begin
         sync1     <= pin;
         sync2     <= sync1;
         sync_prev <= sync2;
         raw_prev  <= pin;
      end
   end

   // Raw path skips the phase alignment, two cycles less latency
   assign level = sync_en ? sync2 : pin;
   assign rise  = sync_en ? (sync2 & ~sync_prev) : (pin & ~raw_prev);
   assign fall  = sync_en ? (~sync2 & sync_prev) : (~pin & raw_prev);
endmodule : gtm_edge_det

//--- design/gtm_prescaler.sv
// Input divider for the timer count: one tick per terminal+1 inputs.
// Assumes the caller gates enable with the timer-on bit.
module gtm_prescaler #(
   parameter int W = 8
) (
   // Clock and reset
   input  wire logic         hclk,
   input  wire logic         hresetn,
   // Control
   input  wire logic         enable,
   input  wire logic         clear,
   input  wire logic         in_tick,
   input  wire logic [W-1:0] terminal,
   // Output
   output logic              out_tick
);
   logic [W-1:0] cnt;

   assign out_tick = enable && in_tick && (cnt >= terminal);

   // Clock halted while disabled, so a clear is lost then too
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cnt <= '0;
      end else if (enable) begin
         if (clear || out_tick) begin
            cnt <= '0;
         end else if (in_tick) begin
            cnt <= cnt + 1'b1;
         end
      end
   end
endmodule : gtm_prescaler

//--- design/gtm_timer.sv
// 16-bit timer/counter with real-time-clock base, AHB-Lite slave.
// Assumes CPU idle and sleep levels and all pins synchronous to hclk.
//
// Behaviour
// RQ1 - Internal mode counts cycles, wraps at period
// RQ2 - Stop-in-idle halts counting during CPU idle
// RQ3 - Synchronous counter counts synchronised external edges
// RQ4 - Asynchronous counter counts raw edges, idle-stoppable
// RQ5 - Gated mode counts only while gate high
// RQ6 - Gate falling edge raises the interrupt flag
// RQ7 - Prescaler divides by 1, 8, 64, 256
// RQ8 - Counter or control writes clear prescaler
// RQ9 - Disabled timer cannot clear its prescaler
// RQ10 - Control write leaves the count unchanged
// RQ11 - Sleep counting needs on, external, asynchronous
// RQ12 - Match during sleep can request interrupt
// RQ13 - Match sets flag; software clears it
// RQ14 - Sync bit zero counts external clock raw
// RQ15 - Clock mode counts low-power oscillator edges
// RQ16 - Real-time-clock software keeps sync bit zero
// RQ17 - Oscillator enable replaces modes, carry wakes
// RQ18 - Clock counting continues through sleep
// RQ19 - Timer off holds count, no matches
//
// Our own choice: the AHB-Lite slave port.
module gtm_timer (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // CPU power state
   input  wire logic        cpu_idle,
   input  wire logic        cpu_sleep,
   // Pins
   input  wire logic        ext_clock_gate_pin,
   input  wire logic        lp_osc_clk,
   // Events
   output logic             irq,
   output logic             wake
);
   import gtm_pkg::*;

   gtm_ctrl_t         ctrl;
   logic [15:0]       count_value;
   logic [15:0]       period_value;
   logic [ST_W-1:0]   irq_status;
   logic [ST_W-1:0]   irq_mask;
   logic              lowpower_osc_enable;
   gtm_aphase_t       aph;
   logic [ADDR_W-1:0] req_index;
   logic              rd_take;
   logic              wr_cnt;
   logic              wr_per;
   logic              wr_ctl;
   logic              wr_msk;
   logic              wr_osc;
   logic              rd_status;
   logic              gate_level;
   logic              gate_rise;
   logic              gate_fall;
   logic              ext_rise;
   logic              osc_rise;
   logic              src_tick;
   logic              run;
   logic              pre_tick;
   logic              at_period;
   logic              match;
   logic              carry;
   logic              gate_end;
   logic [31:0]       next_rdata;

   // Bus slave: zero wait states, always OKAY
   assign hreadyout = 1'b1;
   assign hresp     = HRESP_OKAY;
   assign req_index = haddr[ADDR_LSB +: ADDR_W];
   assign rd_take   = hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         aph <= '0;
      end else if (hready) begin
         aph.valid <= hsel && (htrans == HTRANS_NONSEQ);
         aph.write <= hwrite;
         aph.index <= req_index;
      end
   end

   // Write strobes land in the data phase
   assign wr_cnt = aph.valid && aph.write && (aph.index == ADDR_W'(IDX_COUNT));
   assign wr_per = aph.valid && aph.write && (aph.index == ADDR_W'(IDX_PERIOD));
   assign wr_ctl = aph.valid && aph.write && (aph.index == ADDR_W'(IDX_CONTROL));
   assign wr_msk = aph.valid && aph.write && (aph.index == ADDR_W'(IDX_MASK));
   assign wr_osc = aph.valid && aph.write && (aph.index == ADDR_W'(IDX_OSC));
   assign rd_status = rd_take && (req_index == ADDR_W'(IDX_STATUS));

   always_comb begin
      next_rdata = '0;
      unique case (req_index)
         ADDR_W'(IDX_COUNT):   next_rdata[15:0] = count_value;
         ADDR_W'(IDX_PERIOD):  next_rdata[15:0] = period_value;
         ADDR_W'(IDX_CONTROL): next_rdata[15:0] = ctrl;
         ADDR_W'(IDX_STATUS):  next_rdata[ST_W-1:0] = irq_status;
         ADDR_W'(IDX_MASK):    next_rdata[ST_W-1:0] = irq_mask;
         ADDR_W'(IDX_OSC):     next_rdata[OSC_LPE] = lowpower_osc_enable;
         default:              next_rdata = '0;
      endcase
   end

   // Read data sampled at the address phase, so a read right after
   // a write to the same register still sees the old value
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (rd_take) begin
         hrdata <= next_rdata;
      end
   end

   // Software registers
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl <= CONTROL_RST;
      end else if (wr_ctl) begin
         ctrl <= hwdata[15:0] & CONTROL_WMASK;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         period_value <= PERIOD_RST;
      end else if (wr_per) begin
         period_value <= hwdata[15:0];
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_mask            <= '0;
         lowpower_osc_enable <= 1'b0;
      end else begin
         if (wr_msk) begin
            irq_mask <= hwdata[ST_W-1:0];
         end
         if (wr_osc) begin
            lowpower_osc_enable <= hwdata[OSC_LPE];
         end
      end
   end

   // Pin front ends
   gtm_edge_det u_gate (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin     (ext_clock_gate_pin),
      .sync_en (ctrl.ext_clock_sync), // RQ3 RQ14
      .level   (gate_level),
      .rise    (gate_rise),
      .fall    (gate_fall)
   );

   // Oscillator is asynchronous by nature, never phase aligned
   gtm_edge_det u_osc (
      .hclk    (hclk),
      .hresetn (hresetn),
      .pin     (lp_osc_clk),
      .sync_en (1'b0),
      .level   (),
      .rise    (osc_rise),
      .fall    ()
   );

   // Low-power oscillator replaces the external pin as source
   assign ext_rise = lowpower_osc_enable ? osc_rise : gate_rise; // RQ15 RQ17

   always_comb begin
      if (lowpower_osc_enable) begin
         src_tick = ctrl.clock_source_select && !ctrl.gate_enable && osc_rise; // RQ15 RQ17
      end else if (ctrl.clock_source_select) begin
         src_tick = ext_rise; // RQ3 RQ4
      end else if (ctrl.gate_enable) begin
         src_tick = gate_level; // RQ5
      end else begin
         src_tick = 1'b1; // RQ1
      end
   end

   // Run conditions: on, not idle-stopped, sleep only if async external
   always_comb begin
      run = ctrl.timer_on; // RQ19
      if (cpu_idle && ctrl.stop_in_idle) begin
         run = 1'b0; // RQ2 RQ4
      end
      if (cpu_sleep && !(ctrl.clock_source_select && !ctrl.ext_clock_sync)) begin
         run = 1'b0; // RQ11 RQ18
      end
   end

   gtm_prescaler #(
      .W (PS_W)
   ) u_pre (
      .hclk     (hclk),
      .hresetn  (hresetn),
      .enable   (ctrl.timer_on), // RQ9
      .clear    (wr_cnt || wr_ctl), // RQ8
      .in_tick  (run && src_tick),
      .terminal (PS_TERM[ctrl.prescale_select]), // RQ7
      .out_tick (pre_tick)
   );

   assign at_period = (count_value == period_value);
   assign match     = pre_tick && at_period; // RQ1 RQ13
   assign carry     = pre_tick && (count_value == '1);
   assign gate_end  = ctrl.timer_on && ctrl.gate_enable &&
                      !ctrl.clock_source_select && !lowpower_osc_enable &&
                      gate_fall; // RQ6

   // Counter: only a direct write changes it besides counting
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         count_value <= COUNT_RST;
      end else if (wr_cnt) begin
         count_value <= hwdata[15:0]; // RQ10
      end else if (match) begin
         count_value <= '0; // RQ1 RQ3 RQ4 RQ11
      end else if (pre_tick) begin
         count_value <= count_value + 1'b1;
      end
   end

   // Sticky status; a new event wins over the clearing read
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_status <= '0;
      end else begin
         for (int i = 0; i < ST_W; i++) begin
            if (rd_status) begin
               irq_status[i] <= 1'b0;
            end
         end
         if (match || gate_end) begin
            irq_status[ST_IRQ] <= 1'b1; // RQ13 RQ6 RQ12
         end
         if (lowpower_osc_enable && carry) begin
            irq_status[ST_WAKE] <= 1'b1; // RQ17
         end
      end
   end

   // Level interrupt, works in sleep since hclk keeps running here
   assign irq  = |(irq_status & irq_mask); // RQ12 RQ13
   assign wake = irq_status[ST_WAKE] && irq_mask[ST_WAKE]; // RQ17
endmodule : gtm_timer

//--- verif/gtm_timer_properties.sv
// Checker on the timer's ports: bus replies and event outputs.
// Assumes a single AHB-Lite master; bound at the foot.
module gtm_timer_properties
   import gtm_pkg::*;
(
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic [31:0] hwdata,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic        cpu_idle,
   input wire logic        cpu_sleep,
   input wire logic        irq,
   input wire logic        wake
);
   timeunit 1ns;
   timeprecision 1ps;
   logic        wr_ph;
   logic        mwr;
   logic [ADDR_W-1:0] wr_idx;
   logic [15:0] ctl;
   logic [15:0] msk;
   // Shadows load at the write data phase, as the registers do
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph  <= 1'b0;
         wr_idx <= '0;
         mwr    <= 1'b0;
         ctl    <= 16'h0000;
         msk    <= 16'h0000;
      end else begin
         wr_ph  <= hsel & hready & (htrans == HTRANS_NONSEQ) & hwrite;
         wr_idx <= haddr[ADDR_LSB +: ADDR_W];
         mwr    <= wr_ph & (wr_idx == ADDR_W'(IDX_MASK));
         if (wr_ph && wr_idx == ADDR_W'(IDX_CONTROL)) ctl <= hwdata[15:0] & CONTROL_WMASK;
         if (wr_ph && wr_idx == ADDR_W'(IDX_MASK)) msk <= hwdata[15:0];
      end
   end
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // New request that no mask write explains
   sequence s_new_irq;
      $rose(irq) && !mwr;
   endsequence
   a_resp_okay: assert property (hresp == HRESP_OKAY)
      else $error("reply not okay");
   a_no_wait: assert property (hreadyout)
      else $error("wait state");
   a_upper_zero: assert property (hrdata[31:16] == 16'h0)
      else $error("upper read bits set");
   a_irq_masked: assert property (irq |-> msk[1:0] != 2'h0)
      else $error("irq while masked");
   a_wake_irq: assert property (wake |-> irq && msk[ST_WAKE])
      else $error("wake without irq");
   a_off_quiet: assert property (s_new_irq |-> ctl[15] || $past(ctl[15]))
      else $error("event while off");
   a_idle_stop: assert property (s_new_irq |->
      !($past(cpu_idle) && ctl[13] && !ctl[6] && $stable(ctl)))
      else $error("event in idle stop");
   a_sleep_stop: assert property (s_new_irq |->
      !($past(cpu_sleep) && !(ctl[1] && !ctl[2]) && !ctl[6] && $stable(ctl)))
      else $error("event in sleep");
endmodule : gtm_timer_properties

bind gtm_timer gtm_timer_properties gtm_timer_properties_inst (
   .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hrdata,
   .hreadyout, .hresp, .cpu_idle, .cpu_sleep, .irq, .wake);

//--- verif/gtm_pin_model.sv
// Far side: timer pin (clock or gate) and slow oscillator.
// Assumes stepping on hclk; both lines rest low between bursts.
module gtm_pin_model (
   // Clock
   input  wire logic hclk,
   // Driven lines
   output logic      pin,
   output logic      osc
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      pin = 1'b0;
      osc = 1'b0;
   end
   // n pulses, h cycles low then h high; one long pulse is a gate
   task automatic pulses(input int n, input int h);
      repeat (n) begin
         repeat (h) @(posedge hclk);
         pin <= 1'b1;
         repeat (h) @(posedge hclk);
         pin <= 1'b0;
      end
   endtask : pulses
   // Far slower than hclk in reality; shortened to save run time
   task automatic ticks(input int n);
      repeat (n) begin
         repeat (5) @(posedge hclk);
         osc <= 1'b1;
         repeat (5) @(posedge hclk);
         osc <= 1'b0;
      end
   endtask : ticks
endmodule : gtm_pin_model

//--- verif/test_gp_timer16_with_rtc.sv
// Self-checking bench for the 16-bit timer on AHB-Lite.
// Assumes the pin model drives the pin and the slow clock.
module test_gp_timer16_with_rtc;
   timeunit 1ns;
   timeprecision 1ps;
   import gtm_pkg::*;
   logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
   logic        cpu_idle, cpu_sleep, pin, osc, irq, wake;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   int          num_errors, cmp_count, cyc;
   assign hready = hreadyout;
   gtm_timer gtm_timer_inst (
      .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
      .hrdata, .hreadyout, .hresp, .cpu_idle, .cpu_sleep, .ext_clock_gate_pin(pin),
      .lp_osc_clk(osc), .irq, .wake);
   gtm_pin_model gtm_pin_model_inst (.hclk, .pin, .osc);
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // Tests need about 4500 cycles
   always @(posedge hclk) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         stop_test();
      end
   end
   task automatic stop_test();
      $display("checks %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : stop_test
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic bus(input logic [11:0] idx, input logic w, input logic [15:0] d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {18'h0, idx, 2'h0};
      htrans <= HTRANS_NONSEQ;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {16'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : bus
   task automatic rchk(input string nm, input logic [11:0] idx, input logic [31:0] exp);
      bus(idx, 1'b0, 16'h0);
      chk(nm, exp, rd);
   endtask : rchk
   task automatic t_regs();
      rchk("period", IDX_PERIOD, 32'(PERIOD_RST));
      rchk("control", IDX_CONTROL, 32'(CONTROL_RST));
      bus(IDX_CONTROL, 1'b1, 16'h5fff);
      rchk("ctl bits", IDX_CONTROL, 32'h76);
      rchk("unmapped", 12'h0ff, 32'h0);
      $display("regs done");
   endtask : t_regs
   task automatic t_internal();
      logic [31:0] v;
      bus(IDX_MASK, 1'b1, 16'h1);
      bus(IDX_PERIOD, 1'b1, 16'h4);
      bus(IDX_COUNT, 1'b1, 16'h0);
      bus(IDX_CONTROL, 1'b1, 16'h8000);
      repeat (4) @(posedge hclk);
      #1 chk("irq early", 32'h0, 32'(irq));
      @(posedge hclk);
      #1 chk("irq match", 32'h1, 32'(irq));
      rchk("flag", IDX_STATUS, 32'h1);
      bus(IDX_CONTROL, 1'b1, 16'h0);
      bus(IDX_STATUS, 1'b0, 16'h0);
      bus(IDX_COUNT, 1'b0, 16'h0);
      v = rd;
      chk("wrap", 32'h1, 32'(v <= 32'h4));
      repeat (20) @(posedge hclk);
      rchk("off flag", IDX_STATUS, 32'h0);
      bus(IDX_COUNT, 1'b1, 16'h0123);
      bus(IDX_CONTROL, 1'b1, 16'h0030);
      rchk("count kept", IDX_COUNT, 32'h123);
      $display("internal done");
   endtask : t_internal
   task automatic t_prescale();
      int dv[4] = '{1, 8, 64, 256};
      bus(IDX_PERIOD, 1'b1, 16'hffff);
      for (int p = 0; p < 4; p++) begin
         bus(IDX_CONTROL, 1'b1, 16'h8000 | 16'(p << 4));
         bus(IDX_COUNT, 1'b1, 16'h0);
         // Residue of 5 per 8 shows a lost prescaler clear
         repeat (1018) @(posedge hclk);
         bus(IDX_CONTROL, 1'b1, 16'h0);
         rchk("scaled", IDX_COUNT, 32'(1021 / dv[p]));
      end
      $display("prescale done");
   endtask : t_prescale
   task automatic t_ext();
      for (int s = 0; s < 2; s++) begin
         bus(IDX_CONTROL, 1'b1, 16'h8002 | 16'(s << 2));
         bus(IDX_COUNT, 1'b1, 16'h0);
         gtm_pin_model_inst.pulses(3, 3);
         cpu_sleep <= 1'b1;
         gtm_pin_model_inst.pulses(4, 3);
         cpu_sleep <= 1'b0;
         rchk("ext count", IDX_COUNT, (s == 0) ? 32'h7 : 32'h3);
      end
      $display("external done");
   endtask : t_ext
   task automatic t_gate();
      bus(IDX_CONTROL, 1'b1, 16'h8040);
      bus(IDX_COUNT, 1'b1, 16'h0);
      gtm_pin_model_inst.pulses(1, 20);
      rchk("gated", IDX_COUNT, 32'd20);
      #1 chk("gate irq", 32'h1, 32'(irq));
      bus(IDX_MASK, 1'b1, 16'h0);
      #1 chk("masked", 32'h0, 32'(irq));
      bus(IDX_MASK, 1'b1, 16'h1);
      rchk("gate flag", IDX_STATUS, 32'h1);
      #1 chk("cleared", 32'h0, 32'(irq));
      $display("gate done");
   endtask : t_gate
   task automatic t_idle();
      @(posedge hclk);
      cpu_idle <= 1'b1;
      bus(IDX_CONTROL, 1'b1, 16'ha000);
      bus(IDX_COUNT, 1'b1, 16'h0);
      repeat (30) @(posedge hclk);
      rchk("idle held", IDX_COUNT, 32'h0);
      bus(IDX_CONTROL, 1'b1, 16'h8000);
      repeat (30) @(posedge hclk);
      bus(IDX_COUNT, 1'b0, 16'h0);
      chk("idle runs", 32'h1, 32'(rd != 32'h0));
      cpu_idle <= 1'b0;
      $display("idle done");
   endtask : t_idle
   task automatic t_rtc();
      bus(IDX_OSC, 1'b1, 16'h2);
      bus(IDX_MASK, 1'b1, 16'h3);
      bus(IDX_STATUS, 1'b0, 16'h0);
      bus(IDX_CONTROL, 1'b1, 16'h8002);
      bus(IDX_COUNT, 1'b1, 16'hfffe);
      cpu_sleep <= 1'b1;
      // Pin edges must be ignored here
      gtm_pin_model_inst.pulses(3, 2);
      gtm_pin_model_inst.ticks(2);
      #1 chk("wake", 32'h1, 32'(wake));
      chk("sleep irq", 32'h1, 32'(irq));
      @(posedge hclk);
      cpu_sleep <= 1'b0;
      rchk("rtc flags", IDX_STATUS, 32'h3);
      rchk("rtc count", IDX_COUNT, 32'h0);
      $display("rtc done");
   endtask : t_rtc
   initial begin
      {hresetn, hsel, hwrite, cpu_idle, cpu_sleep} = 5'h0;
      {haddr, hwdata} = 64'h0;
      htrans = 2'h0;
      hsize = 3'h2;
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      t_regs();
      t_internal();
      t_prescale();
      t_ext();
      t_gate();
      t_idle();
      t_rtc();
      stop_test();
   end
endmodule : test_gp_timer16_with_rtc
